// ===== common/bpdp_pkg.sv
// Purpose: Shared constants and types for the port D pin block.
// Assumes: 32-bit APB data, 12-bit byte address, eight pins.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package bpdp_pkg;

  // Port geometry
  localparam int          BPDP_PINS      = 8;
  localparam int          BPDP_AW        = 12;
  localparam int          BPDP_DW        = 32;

  // Register byte offsets
  localparam logic [11:0] OFS_PIN        = 12'h000;
  localparam logic [11:0] OFS_DIR        = 12'h004;
  localparam logic [11:0] OFS_LAT        = 12'h008;
  localparam logic [11:0] OFS_EDIR       = 12'h00C;
  localparam logic [11:0] OFS_ANA        = 12'h010;
  localparam logic [11:0] OFS_PWM        = 12'h014;
  localparam logic [11:0] OFS_STAT       = 12'h018;

  // Reset values
  localparam logic [7:0]  RST_DIR        = 8'hFF;
  localparam logic [7:0]  RST_LAT        = 8'h00;
  localparam logic [7:0]  RST_EDIR       = 8'h07;
  localparam logic [7:0]  RST_ANA        = 8'h0F;
  localparam logic [7:0]  RST_PAD_OUT    = 8'h00;
  localparam logic [7:0]  RST_PAD_OE     = 8'h00;

  // Field positions
  localparam int          PSP_EN_BIT     = 4;
  localparam int          PWM_MODE_LSB   = 0;
  localparam int          STAT_PSP_BIT   = 0;
  localparam int          STAT_TTL_BIT   = 1;
  localparam int          STAT_OE_LSB    = 8;
  localparam int          STAT_PWM_LSB   = 16;

  // Pins that can carry a comparator input
  localparam logic [7:0]  ANALOG_PIN_MASK = 8'h0F;

  // Pins carrying pwm channels A to D
  localparam int          PWM_A_PIN      = 4;
  localparam int          PWM_B_PIN      = 5;
  localparam int          PWM_C_PIN      = 6;
  localparam int          PWM_D_PIN      = 7;

  // Enhanced pwm output modes
  typedef enum logic [1:0] {
    PWM_OFF,
    PWM_SINGLE,
    PWM_DUAL,
    PWM_QUAD
  } bpdp_pwm_mode_t;

  // Register selected by an address
  typedef enum logic [2:0] {
    REG_PIN,
    REG_DIR,
    REG_LAT,
    REG_EDIR,
    REG_ANA,
    REG_PWM,
    REG_STAT,
    REG_NONE
  } bpdp_reg_t;

  // APB slave states
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_ACCESS
  } bpdp_apb_state_t;

  // APB request from the master
  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } bpdp_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } bpdp_apb_rsp_t;

  // Pwm channel levels from the pwm unit
  typedef struct packed {
    logic d;
    logic c;
    logic b;
    logic a;
  } bpdp_pwm_t;

endpackage

// ===== logic/bpdp_in_stage.sv
// Purpose: Samples the pad inputs and applies the analog override.
// Assumes: Pad inputs are synchronous to CORE_CLK.
// Notes:   Buffer threshold choice is driven out to the pad cell.
`timescale 1ns/1ps
module bpdp_in_stage (
  input  wire logic       clk,        // Core clock
  input  wire logic       rst,        // Sync reset, high
  input  wire logic       ce,         // Clock enable
  input  wire logic [7:0] pad_in,     // Pad levels
  input  wire logic [7:0] ana_sel,    // Analog selected pins
  input  wire logic       psp_act,    // Slave port active
  output logic      [7:0] pins_q,     // Sampled levels
  output logic            ttl_sel_q   // Threshold select
);
  import bpdp_pkg::*;

  logic [7:0] pins_d;

  // Analog pins read low, others pass through
  always_comb begin
    pins_d = pad_in & ~(ana_sel & ANALOG_PIN_MASK);
  end

  // Sample register for the digital input path
  always_ff @(posedge clk) begin
    if (rst) begin
      pins_q <= 8'h00;
    end else if (ce) begin
      pins_q <= pins_d;
    end
  end

  // Schmitt buffers normally, TTL in slave port mode
  always_ff @(posedge clk) begin
    if (rst) begin
      ttl_sel_q <= 1'b0;
    end else if (ce) begin
      ttl_sel_q <= psp_act;
    end
  end

endmodule

// ===== logic/bpdp_pin_mux.sv
// Purpose: Per-pin output selection between latch, pwm and slave port.
// Assumes: All selects are already resolved by the register block.
// Notes:   Outputs are registered, so pads change one cycle later.
`timescale 1ns/1ps
module bpdp_pin_mux (
  input  wire logic       clk,        // Core clock
  input  wire logic       rst,        // Sync reset, high
  input  wire logic       ce,         // Clock enable
  input  wire logic [7:0] dir,        // Direction, 1 = input
  input  wire logic [7:0] lat,        // Output latch
  input  wire logic       psp_act,    // Slave port active
  input  wire logic [7:0] psp_dout,   // Slave port data out
  input  wire logic [7:0] psp_doe,    // Slave port drive enable
  input  wire logic [7:0] pwm_en,     // Pwm channel on this pin
  input  wire logic [7:0] pwm_val,    // Pwm level on this pin
  output logic      [7:0] out_q,      // Pad output level
  output logic      [7:0] oe_q        // Pad output enable
);
  import bpdp_pkg::*;

  genvar i;
  generate
    for (i = 0; i < BPDP_PINS; i++) begin : g_pin
      logic out_d;
      logic oe_d;

      // Slave port first, then pwm, then the latch
      always_comb begin
        out_d = lat[i];
        oe_d  = ~dir[i];
        if (psp_act) begin
          out_d = psp_dout[i];
          oe_d  = psp_doe[i];
        end else if (pwm_en[i] && !dir[i]) begin
          out_d = pwm_val[i];
          oe_d  = 1'b1;
        end
      end

      // Registered pad drive, released at reset
      always_ff @(posedge clk) begin
        if (rst) begin
          out_q[i] <= RST_PAD_OUT[i];
          oe_q[i]  <= RST_PAD_OE[i];
        end else if (ce) begin
          out_q[i] <= out_d;
          oe_q[i]  <= oe_d;
        end
      end
    end
  endgenerate

endmodule

// ===== logic/bpdp_port.sv
// Purpose: Eight-pin bidirectional port with APB registers.
// Assumes: One clock; pads resolve the wire from PAD_OE outside.
// Notes:   Zero-wait APB slave; pad drive lags a write by one cycle.
`timescale 1ns/1ps
module bpdp_port #(
  parameter int WIDTH = 8                        // Pin count
) (
  input  wire logic                    CORE_CLK,    // Core clock
  input  wire logic                    RESET,       // Sync reset, high
  input  wire logic                    CORE_CE,     // Clock enable
  input  wire bpdp_pkg::bpdp_apb_req_t APB_REQ,     // APB request
  output bpdp_pkg::bpdp_apb_rsp_t      APB_RSP,     // APB answer
  input  wire logic [7:0]              PAD_IN,      // Pad levels
  output logic      [7:0]              PAD_OUT,     // Pad drive level
  output logic      [7:0]              PAD_OE,      // Pad drive enable
  output logic                         PAD_TTL_SEL, // 1 = TTL buffers
  output logic                         PSP_ACTIVE,  // Slave port active
  output logic      [7:0]              PSP_DIN,     // Pins to slave port
  input  wire logic [7:0]              PSP_DOUT,    // Slave port data
  input  wire logic [7:0]              PSP_DOE,     // Slave port enable
  input  wire bpdp_pkg::bpdp_pwm_t     PWM_IN       // Pwm channel levels
);
  import bpdp_pkg::*;

  // Elaboration check on the pin count
  generate
    if (WIDTH != BPDP_PINS) begin : g_bad_width
      $error("bpdp_port supports exactly eight pins");
    end
  endgenerate

  // Register state
  logic            [7:0] dir_q;
  logic            [7:0] lat_q;
  logic            [7:0] edir_q;
  logic            [7:0] ana_q;
  bpdp_pwm_mode_t        pwm_mode_q;

  // Bus state
  bpdp_apb_state_t       state_q;
  bpdp_apb_state_t       state_d;
  logic           [31:0] prdata_q;
  logic           [31:0] prdata_d;
  logic                  pslverr_q;
  logic                  pslverr_d;

  // Derived controls
  logic                  psp_act;
  logic                  pwm_multi;
  logic            [7:0] pwm_en;
  logic            [7:0] pwm_val;
  logic            [7:0] pins_q;
  logic                  ttl_sel_q;
  logic            [7:0] pad_out_q;
  logic            [7:0] pad_oe_q;

  // Bus events
  logic                  setup_ev;
  logic                  wr_ev;
  bpdp_reg_t             rd_sel;
  bpdp_reg_t             wr_sel;

  // Address to register, shared by read and write paths
  function automatic bpdp_reg_t bpdp_decode(input logic [11:0] addr);
    bpdp_reg_t sel;
    sel = REG_NONE;
    if (addr == OFS_PIN) begin
      sel = REG_PIN;
    end else if (addr == OFS_DIR) begin
      sel = REG_DIR;
    end else if (addr == OFS_LAT) begin
      sel = REG_LAT;
    end else if (addr == OFS_EDIR) begin
      sel = REG_EDIR;
    end else if (addr == OFS_ANA) begin
      sel = REG_ANA;
    end else if (addr == OFS_PWM) begin
      sel = REG_PWM;
    end else if (addr == OFS_STAT) begin
      sel = REG_STAT;
    end else begin
      sel = REG_NONE;
    end
    return sel;
  endfunction

  // Setup cycle and the completing access edge
  always_comb begin
    setup_ev = APB_REQ.psel && !APB_REQ.penable;
    wr_ev    = (state_q == ST_ACCESS) && APB_REQ.psel &&
               APB_REQ.penable && APB_REQ.pwrite;
    rd_sel   = bpdp_decode(APB_REQ.paddr);
    wr_sel   = bpdp_decode(APB_REQ.paddr);
  end

  // Slave port needs its enable bit and no multi-output pwm
  always_comb begin
    pwm_multi = (pwm_mode_q == PWM_DUAL) || (pwm_mode_q == PWM_QUAD);
    psp_act   = edir_q[PSP_EN_BIT] && !pwm_multi;
  end

  // Pwm channels claimed per mode, mapped onto their pins
  always_comb begin
    pwm_en  = 8'h00;
    pwm_val = 8'h00;
    pwm_val[PWM_A_PIN] = PWM_IN.a;
    pwm_val[PWM_B_PIN] = PWM_IN.b;
    pwm_val[PWM_C_PIN] = PWM_IN.c;
    pwm_val[PWM_D_PIN] = PWM_IN.d;
    case (pwm_mode_q)
      PWM_OFF: begin
        pwm_en = 8'h00;
      end
      PWM_SINGLE: begin
        pwm_en[PWM_A_PIN] = 1'b1;
      end
      PWM_DUAL: begin
        pwm_en[PWM_A_PIN] = 1'b1;
        pwm_en[PWM_B_PIN] = 1'b1;
      end
      PWM_QUAD: begin
        pwm_en[PWM_A_PIN] = 1'b1;
        pwm_en[PWM_B_PIN] = 1'b1;
        pwm_en[PWM_C_PIN] = 1'b1;
        pwm_en[PWM_D_PIN] = 1'b1;
      end
      default: begin
        pwm_en = 8'h00;
      end
    endcase
  end

  // Direction register, all inputs after reset
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      dir_q <= RST_DIR;
    end else if (CORE_CE && wr_ev && wr_sel == REG_DIR) begin
      dir_q <= APB_REQ.pwdata[7:0];
    end
  end

  // Output latch, written through pin or latch address
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      lat_q <= RST_LAT;
    end else if (CORE_CE && wr_ev &&
                 (wr_sel == REG_PIN || wr_sel == REG_LAT)) begin
      lat_q <= APB_REQ.pwdata[7:0];
    end
  end

  // Port E direction register holding the slave enable
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      edir_q <= RST_EDIR;
    end else if (CORE_CE && wr_ev && wr_sel == REG_EDIR) begin
      edir_q <= APB_REQ.pwdata[7:0];
    end
  end

  // Analog select, comparator pins analog after reset
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      ana_q <= RST_ANA;
    end else if (CORE_CE && wr_ev && wr_sel == REG_ANA) begin
      ana_q <= APB_REQ.pwdata[7:0] & ANALOG_PIN_MASK;
    end
  end

  // Pwm output mode
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      pwm_mode_q <= PWM_OFF;
    end else if (CORE_CE && wr_ev && wr_sel == REG_PWM) begin
      pwm_mode_q <= bpdp_pwm_mode_t'(APB_REQ.pwdata[PWM_MODE_LSB +: 2]);
    end
  end

  // Bus state: setup moves to access, access ends after one cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (setup_ev) begin
          state_d = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      state_q <= ST_IDLE;
    end else if (CORE_CE) begin
      state_q <= state_d;
    end
  end

  // Read data and error, picked in the setup cycle
  always_comb begin
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    if (setup_ev && state_q == ST_IDLE) begin
      prdata_d  = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (rd_sel == REG_PIN) begin
        prdata_d[7:0] = pins_q;
      end else if (rd_sel == REG_DIR) begin
        prdata_d[7:0] = dir_q;
      end else if (rd_sel == REG_LAT) begin
        prdata_d[7:0] = lat_q;
      end else if (rd_sel == REG_EDIR) begin
        prdata_d[7:0] = edir_q;
      end else if (rd_sel == REG_ANA) begin
        prdata_d[7:0] = ana_q;
      end else if (rd_sel == REG_PWM) begin
        prdata_d[PWM_MODE_LSB +: 2] = pwm_mode_q;
      end else if (rd_sel == REG_STAT) begin
        prdata_d[STAT_PSP_BIT]      = psp_act;
        prdata_d[STAT_TTL_BIT]      = ttl_sel_q;
        prdata_d[STAT_OE_LSB +: 8]  = pad_oe_q;
        prdata_d[STAT_PWM_LSB +: 8] = pwm_en;
      end else begin
        pslverr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (CORE_CE) begin
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Input sampling and buffer threshold
  bpdp_in_stage u_in (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .ce        (CORE_CE),
    .pad_in    (PAD_IN),
    .ana_sel   (ana_q),
    .psp_act   (psp_act),
    .pins_q    (pins_q),
    .ttl_sel_q (ttl_sel_q)
  );

  // Output selection per pin
  bpdp_pin_mux u_mux (
    .clk      (CORE_CLK),
    .rst      (RESET),
    .ce       (CORE_CE),
    .dir      (dir_q),
    .lat      (lat_q),
    .psp_act  (psp_act),
    .psp_dout (PSP_DOUT),
    .psp_doe  (PSP_DOE),
    .pwm_en   (pwm_en),
    .pwm_val  (pwm_val),
    .out_q    (pad_out_q),
    .oe_q     (pad_oe_q)
  );

  // Outputs
  always_comb begin
    APB_RSP.prdata  = prdata_q;
    APB_RSP.pready  = (state_q == ST_ACCESS);
    APB_RSP.pslverr = pslverr_q && (state_q == ST_ACCESS);
    PAD_OUT         = pad_out_q;
    PAD_OE          = pad_oe_q;
    PAD_TTL_SEL     = ttl_sel_q;
    PSP_ACTIVE      = psp_act;
    PSP_DIN         = pins_q;
  end

endmodule

// ===== test/bpdp_pad_model.sv
// Purpose: Board-side pin model with drivers and pull-ups.
// Assumes: Board drivers yield where the device drives.
// Notes:   Undriven pins float high through pull-ups.
`timescale 1ns/1ps
module bpdp_pad_model (
  input  wire logic [7:0] pad_out,  // Device drive level
  input  wire logic [7:0] pad_oe,   // Device drive enable
  input  wire logic [7:0] ext_val,  // Board drive level
  input  wire logic [7:0] ext_drv,  // Board drive enable
  output logic      [7:0] pad_in    // Resolved pin level
);
  // Device first, then board, else pull-up
  always_comb begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drv & ext_val) |
             (~pad_oe & ~ext_drv);
  end
endmodule

// ===== test/bpdp_port_assertions.sv
// Purpose: Port-level checker for the eight-pin port block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Sees only top-level ports; attached by bind below.
`timescale 1ns/1ps
module bpdp_port_chk
  import bpdp_pkg::*;
(
  input wire logic                    CORE_CLK,    // Core clock
  input wire logic                    RESET,       // Sync reset, high
  input wire logic                    CORE_CE,     // Clock enable
  input wire bpdp_pkg::bpdp_apb_req_t APB_REQ,     // APB request
  input wire bpdp_pkg::bpdp_apb_rsp_t APB_RSP,     // APB answer
  input wire logic [7:0]              PAD_IN,      // Pad levels
  input wire logic [7:0]              PAD_OUT,     // Pad drive level
  input wire logic [7:0]              PAD_OE,      // Pad drive enable
  input wire logic                    PAD_TTL_SEL, // TTL select
  input wire logic                    PSP_ACTIVE,  // Slave port active
  input wire logic [7:0]              PSP_DIN,     // Pins to slave port
  input wire logic [7:0]              PSP_DOUT,    // Slave port data
  input wire logic [7:0]              PSP_DOE      // Slave port enable
);
  import bpdp_pkg::*;

  // Common clock and reset
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RESET);

  // Pins come out of reset as plain inputs
  a_reset_inputs: assert property (
    $past(RESET) |-> PAD_OE == 8'h00 && !PSP_ACTIVE && !PAD_TTL_SEL)
    else $error("pads not idle after reset");
  // Zero-wait answer after a setup cycle
  a_ready_setup: assert property (
    APB_REQ.psel && !APB_REQ.penable && CORE_CE |=> APB_RSP.pready)
    else $error("no ready after setup");
  // Ready only inside an access phase
  a_ready_access: assert property (
    APB_RSP.pready |-> APB_REQ.psel && APB_REQ.penable)
    else $error("ready outside access");
  // Exactly one access cycle
  a_ready_single: assert property (
    APB_RSP.pready && CORE_CE |=> !APB_RSP.pready)
    else $error("ready held too long");
  // Refused transfer returns no data
  a_err_no_data: assert property (
    APB_RSP.pready && APB_RSP.pslverr |-> APB_RSP.prdata == 32'h0)
    else $error("error answer carries data");
  // Buffer threshold follows slave mode
  a_ttl_tracks: assert property (
    CORE_CE |=> PAD_TTL_SEL == $past(PSP_ACTIVE))
    else $error("threshold select wrong");
  // Slave port owns the pads regardless of direction
  a_psp_drive: assert property (
    PSP_ACTIVE && CORE_CE |=> PAD_OE == $past(PSP_DOE) &&
      (PAD_OUT & PAD_OE) == ($past(PSP_DOUT) & $past(PSP_DOE)))
    else $error("slave port not driving pads");
  // Sampled pins never show a high the pad lacked
  a_din_no_invent: assert property (
    CORE_CE |=> (PSP_DIN & ~$past(PAD_IN)) == 8'h00)
    else $error("sampled pin high without pad");

  // Main scenarios reached
  c_psp: cover property (PSP_ACTIVE && PAD_TTL_SEL);
  c_err: cover property (APB_RSP.pready && APB_RSP.pslverr);
  c_drive: cover property (PAD_OE == 8'hFF);
endmodule

bind bpdp_port bpdp_port_chk u_chk (
  .CORE_CLK, .RESET, .CORE_CE, .APB_REQ, .APB_RSP, .PAD_IN, .PAD_OUT,
  .PAD_OE, .PAD_TTL_SEL, .PSP_ACTIVE, .PSP_DIN, .PSP_DOUT, .PSP_DOE
);

// ===== test/tb.sv
// Purpose: Self-checking bench for the eight-pin port block.
// Assumes: Zero-wait APB slave, pads lag a write by one cycle.
// Notes:   Board pins come from the pad model.
`timescale 1ns/1ps
module tb;
  import bpdp_pkg::*;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  logic          ce  = 1'b1;
  bpdp_apb_req_t req = '0;
  bpdp_apb_rsp_t rsp;
  logic [7:0]    pad_in, pad_out, pad_oe, psp_din;
  logic [7:0]    psp_dout = 8'h00, psp_doe = 8'h00;
  logic [7:0]    ext_val = 8'h00, ext_drv = 8'h00;
  logic          ttl, psp_act;
  bpdp_pwm_t     pwm = '0;
  int            errors = 0;
  int            compares = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  bpdp_port DUT (
    .CORE_CLK(clk), .RESET(rst), .CORE_CE(ce), .APB_REQ(req),
    .APB_RSP(rsp), .PAD_IN(pad_in), .PAD_OUT(pad_out), .PAD_OE(pad_oe),
    .PAD_TTL_SEL(ttl), .PSP_ACTIVE(psp_act), .PSP_DIN(psp_din),
    .PSP_DOUT(psp_dout), .PSP_DOE(psp_doe), .PWM_IN(pwm)
  );
  bpdp_pad_model u_pads (
    .pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
    .ext_drv(ext_drv), .pad_in(pad_in)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer, held until ready is seen
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    chk(32'(rsp.pready), 32'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    logic e;
    apb(1'b0, a, 32'h0, v, e);
  endtask

  task automatic settle;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_reset;
    logic [31:0] v;
    chk(32'(pad_oe), 32'h0);
    chk(32'(psp_act), 32'h0);
    rd(OFS_DIR, v);
    chk(v, 32'h0000_00FF);
    $display("test reset done");
  endtask

  task automatic t_dirs;
    logic [31:0] v;
    ext_drv <= 8'hFF;
    ext_val <= 8'h3C;
    wr(OFS_LAT, 8'hA5);
    wr(OFS_DIR, 8'h0F);
    settle;
    chk(32'(pad_oe), 32'hF0);
    chk(32'(pad_out & pad_oe), 32'hA0);
    rd(OFS_LAT, v);
    chk(v, 32'hA5);
    rd(OFS_PIN, v);
    chk(v, 32'hA0);
    wr(OFS_ANA, 8'h00);
    rd(OFS_PIN, v);
    chk(v, 32'hAC);
    chk(32'(psp_din), 32'hAC);
    rd(OFS_STAT, v);
    chk(v, 32'h0000_F000);
    $display("test directions done");
  endtask

  task automatic t_pwm;
    logic [3:0] hi [4];
    // Alternating channel levels against an alternating latch
    hi = '{4'hA, 4'hB, 4'h9, 4'h5};
    pwm <= 4'h5;
    wr(OFS_LAT, 8'hA0);
    wr(OFS_DIR, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(OFS_PWM, 8'(m));
      settle;
      chk(32'(pad_out), {24'h0, hi[m], 4'h0});
    end
    wr(OFS_PWM, 8'h00);
    wr(OFS_DIR, 8'hFF);
    settle;
    chk(32'(pad_oe), 32'h0);
    $display("test pwm done");
  endtask

  task automatic t_psp;
    psp_dout <= 8'h5A;
    psp_doe <= 8'hC3;
    wr(OFS_EDIR, 8'h17);
    settle;
    chk(32'({psp_act, ttl}), 32'h3);
    chk(32'(pad_oe), 32'hC3);
    chk(32'(pad_out & pad_oe), 32'h42);
    for (int m = 1; m < 4; m++) begin
      wr(OFS_PWM, 8'(m));
      settle;
      chk(32'(psp_act), 32'(m == 1));
    end
    wr(OFS_PWM, 8'h00);
    wr(OFS_EDIR, 8'h07);
    $display("test slave port done");
  endtask

  task automatic t_refuse;
    logic [31:0] v;
    logic        e;
    apb(1'b0, 12'h01C, 32'h0, v, e);
    chk({31'h0, e}, 32'h1);
    chk(v, 32'h0);
    apb(1'b0, 12'h002, 32'h0, v, e);
    chk(32'(e), 32'h1);
    wr(OFS_STAT, 8'hFF);
    rd(OFS_STAT, v);
    chk(v, 32'h0);
    $display("test refusals done");
  endtask

  // Clock enable low holds the sampled pins
  task automatic t_freeze;
    logic [31:0] v;
    ce <= 1'b0;
    ext_val <= 8'hC3;
    settle;
    chk(32'(psp_din), 32'h3C);
    ce <= 1'b1;
    settle;
    chk(32'(psp_din), 32'hC3);
    rd(OFS_PIN, v);
    chk(v, 32'hC3);
    $display("test clock enable done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_dirs;
    t_pwm;
    t_psp;
    t_refuse;
    t_freeze;
    end_of_test;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clk);
    errors++;
    end_of_test;
  end
endmodule
